// *** include/qbs_pkg.sv ***
// Constants and types for the burst SRAM port logic
// Summary of operation
// - Write select low at link rising edge starts a write burst.
// - Write select high deselects write port; write data is ignored.
// - Write data captured on rising and falling link edges during writes.
// - Four active-low byte selects sampled with each write data beat.
// - Bytes whose select is high keep their stored contents.
// - Shared 18-bit address sampled on rising edge for reads and writes.
// - Address ignored for a port whose select is high.
// - Storage is 1M words of 36 bits, four banks of 256K.
// - Read select low at link rising edge starts a read burst.
// - Each read returns a burst of four sequential words.
// - Read in progress completes; drivers float after next falling edge.
// - Read data driven on both edges; floated when deselected.
// - Output-valid marks read data, aligned with echo clock edges.
// - Accesses start on rising edge, which also launches read data.
// - Echo clocks run continuously, locked to the link clock.
// - PLL disable low selects legacy one-cycle read latency mode.
package qbs_pkg;
    localparam int DATA_W         = 36;
    localparam int ADDR_W         = 18;
    localparam int LANES          = 4;
    localparam int LANE_W         = 9;
    localparam int BURST_LEN      = 4;
    localparam int BANK_DEPTH     = 262144;
    localparam int LEGACY_MAX_MHZ = 167;
    localparam int LAT_NORMAL     = 2;
    localparam int LAT_LEGACY     = 1;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rise;
        logic [DATA_W-1:0] fall;
    } qbs_pair_t;
endpackage : qbs_pkg

// *** rtl/qbs_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/100ps
module qbs_sync (
    input  wire logic clk,
    input  wire logic d,
    output logic      q
);
    logic [1:0] sync_reg;
    logic [1:0] sync_next;

    always_comb begin
        sync_next = {sync_reg[0], d};
    end

    always_ff @(posedge clk) begin
        sync_reg <= sync_next;
    end

    assign q = sync_reg[1];
endmodule : qbs_sync

// *** rtl/qbs_bank.sv ***
// One 256K x 36 storage bank with byte-lane writes
`timescale 1ns/100ps
module qbs_bank (
    input  wire logic                       clk,
    input  wire logic                       we,
    input  wire logic [qbs_pkg::ADDR_W-1:0] wr_idx,
    input  wire logic [qbs_pkg::DATA_W-1:0] wr_data,
    input  wire logic [qbs_pkg::LANES-1:0]  wr_lane_en,
    input  wire logic [qbs_pkg::ADDR_W-1:0] rd_idx,
    output logic      [qbs_pkg::DATA_W-1:0] rd_data
);
    logic [qbs_pkg::DATA_W-1:0] mem [qbs_pkg::BANK_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            for (int i = 0; i < qbs_pkg::LANES; i++) begin
                if (wr_lane_en[i]) begin
                    mem[wr_idx][i*qbs_pkg::LANE_W +: qbs_pkg::LANE_W] <=
                        wr_data[i*qbs_pkg::LANE_W +: qbs_pkg::LANE_W];
                end
            end
        end
    end

    // Old data returned when read and write hit one word on one edge
    assign rd_data = mem[rd_idx];
endmodule : qbs_bank

// *** rtl/qbs_top.sv ***
// Burst SRAM read and write port logic
`timescale 1ns/100ps
module qbs_top (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       pll_disable_n,
    output logic                            legacy_mode,
    input  wire logic                       link_clk,
    input  wire logic                       write_port_select_n,
    input  wire logic                       read_port_select_n,
    input  wire logic [qbs_pkg::ADDR_W-1:0] address,
    input  wire logic [qbs_pkg::DATA_W-1:0] write_data,
    input  wire logic [qbs_pkg::LANES-1:0]  byte_lane_write_select_n,
    output logic      [qbs_pkg::DATA_W-1:0] read_data,
    output logic                            read_data_oe,
    output logic                            read_output_valid,
    output logic                            echo_clock,
    output logic                            echo_clock_n
);
    // System clock side: strap capture
    typedef struct packed {
        logic legacy;
    } qbs_sys_t;

    qbs_sys_t sys_reg;
    qbs_sys_t sys_next;
    logic     pll_dis_sync;

    qbs_sync u_pll_sync (
        .clk (clk),
        .d   (pll_disable_n),
        .q   (pll_dis_sync)
    );

    always_comb begin
        sys_next = sys_reg;
        if (srst) begin
            sys_next.legacy = ~pll_dis_sync;
        end
    end

    always_ff @(posedge clk) begin
        sys_reg <= sys_next;
    end

    assign legacy_mode = sys_reg.legacy;

    // Crossings into the link domain, both plain levels
    logic link_rst;
    logic link_legacy;

    qbs_sync u_rst_sync (
        .clk (link_clk),
        .d   (srst),
        .q   (link_rst)
    );

    qbs_sync u_mode_sync (
        .clk (link_clk),
        .d   (sys_reg.legacy),
        .q   (link_legacy)
    );

    // Link side, rising edge state
    typedef struct packed {
        logic                       wr_second;
        logic                       wr_commit;
        logic [qbs_pkg::ADDR_W-1:0] wr_addr;
        logic [qbs_pkg::DATA_W-1:0] wd0;
        logic [qbs_pkg::DATA_W-1:0] wd1;
        logic [qbs_pkg::DATA_W-1:0] wd2;
        logic [qbs_pkg::LANES-1:0]  bw0;
        logic [qbs_pkg::LANES-1:0]  bw1;
        logic [qbs_pkg::LANES-1:0]  bw2;
        logic                       rd_second;
        qbs_pkg::qbs_pair_t         hold;
        qbs_pkg::qbs_pair_t         pipe0;
        qbs_pkg::qbs_pair_t         pipe1;
        logic [qbs_pkg::DATA_W-1:0] q_rise;
        logic [qbs_pkg::DATA_W-1:0] q_fall_pend;
        logic                       oe;
    } qbs_link_t;

    // Link side, falling edge state
    typedef struct packed {
        logic [qbs_pkg::DATA_W-1:0] d;
        logic [qbs_pkg::LANES-1:0]  bw_n;
        logic [qbs_pkg::DATA_W-1:0] q_fall;
        logic                       oe;
    } qbs_neg_t;

    qbs_link_t lk_reg;
    qbs_link_t lk_next;
    qbs_neg_t  ng_reg;
    qbs_neg_t  ng_next;

    logic [qbs_pkg::BURST_LEN-1:0][qbs_pkg::DATA_W-1:0] bank_rd;
    logic [qbs_pkg::BURST_LEN-1:0][qbs_pkg::DATA_W-1:0] bank_wr;
    logic [qbs_pkg::BURST_LEN-1:0][qbs_pkg::LANES-1:0]  bank_lane_en;
    logic                                               wr_take;
    logic                                               rd_take;
    qbs_pkg::qbs_pair_t                                 launch;

    assign wr_take = ~write_port_select_n & ~lk_reg.wr_second;
    assign rd_take = ~read_port_select_n & ~lk_reg.rd_second;

    // beat words at commit, last beat from falling edge
    always_comb begin
        bank_wr[0]      = lk_reg.wd0;
        bank_wr[1]      = lk_reg.wd1;
        bank_wr[2]      = lk_reg.wd2;
        bank_wr[3]      = ng_reg.d;
        bank_lane_en[0] = ~lk_reg.bw0;
        bank_lane_en[1] = ~lk_reg.bw1;
        bank_lane_en[2] = ~lk_reg.bw2;
        bank_lane_en[3] = ~ng_reg.bw_n;
    end

    // four banks, one per burst beat
    genvar b;
    generate
        for (b = 0; b < qbs_pkg::BURST_LEN; b++) begin : g_bank
            qbs_bank u_bank (
                .clk        (link_clk),
                .we         (lk_reg.wr_commit),
                .wr_idx     (lk_reg.wr_addr),
                .wr_data    (bank_wr[b]),
                .wr_lane_en (bank_lane_en[b]),
                .rd_idx     (address),
                .rd_data    (bank_rd[b])
            );
        end
    endgenerate

    // legacy mode shortens read latency by one cycle
    assign launch = link_legacy ? lk_reg.pipe0 : lk_reg.pipe1;

    always_comb begin
        lk_next           = lk_reg;
        lk_next.wr_commit = 1'b0;
        // shared address taken on rising edge
        // first beat on the starting rising edge
        if (wr_take) begin
            lk_next.wr_second = 1'b1;
            lk_next.wr_addr   = address;
            lk_next.wd0       = write_data;
            lk_next.bw0       = byte_lane_write_select_n;
        end else if (lk_reg.wr_second) begin
            // beats two and three on the next half cycles
            lk_next.wr_second = 1'b0;
            lk_next.wr_commit = 1'b1;
            lk_next.wd1       = ng_reg.d;
            lk_next.bw1       = ng_reg.bw_n;
            lk_next.wd2       = write_data;
            lk_next.bw2       = byte_lane_write_select_n;
        end
        // whole burst fetched, sent as two pairs
        if (rd_take) begin
            lk_next.rd_second = 1'b1;
            lk_next.pipe0     = '{valid: 1'b1, rise: bank_rd[0], fall: bank_rd[1]};
            lk_next.hold      = '{valid: 1'b1, rise: bank_rd[2], fall: bank_rd[3]};
        end else if (lk_reg.rd_second) begin
            lk_next.rd_second  = 1'b0;
            lk_next.pipe0      = lk_reg.hold;
            lk_next.hold.valid = 1'b0;
        end else begin
            lk_next.pipe0.valid = 1'b0;
        end
        lk_next.pipe1       = lk_reg.pipe0;
        lk_next.q_rise      = launch.rise;
        lk_next.q_fall_pend = launch.fall;
        // valid spans exactly the launched pairs
        lk_next.oe          = launch.valid;
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    // captured every falling edge; data and byte selects used only inside a write
    always_comb begin
        ng_next        = ng_reg;
        ng_next.d      = write_data;
        ng_next.bw_n   = byte_lane_write_select_n;
        ng_next.q_fall = lk_reg.q_fall_pend;
        // drivers released only after the next falling edge
        ng_next.oe     = lk_reg.oe;
    end

    always_ff @(negedge link_clk) begin
        if (link_rst) begin
            ng_reg <= '0;
        end else begin
            ng_reg <= ng_next;
        end
    end

    // rising word while clock high, falling word while low
    assign read_data         = link_clk ? lk_reg.q_rise : ng_reg.q_fall;
    // floated once no burst is left
    assign read_data_oe      = lk_reg.oe | ng_reg.oe;
    // valid changes only on rising edges, as the echo clock rises
    assign read_output_valid = lk_reg.oe;
    // echo clocks free running from the link clock
    assign echo_clock        = link_clk;
    assign echo_clock_n      = ~link_clk;
endmodule : qbs_top

// *** sim/qbs_chk_sva.sv ***
// Concurrent checks on the burst SRAM port pins
`timescale 1ns/100ps
module qbs_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic read_port_select_n,
    input wire logic legacy_mode,
    input wire logic read_data_oe,
    input wire logic read_output_valid,
    input wire logic echo_clock,
    input wire logic echo_clock_n
);
    logic rd2_reg;
    logic tk;
    // Second cycle of a burst cannot take a read
    assign tk = !read_port_select_n && !rd2_reg;
    always_ff @(posedge link_clk) begin
        rd2_reg <= srst ? 1'b0 : tk;
    end
    sequence vpair_s;
        read_output_valid ##1 read_output_valid;
    endsequence
    rd_lat_norm_a: assert property (@(posedge link_clk) disable iff (srst)
        tk && !legacy_mode |-> ##3 vpair_s) else $error("normal read valid misplaced");
    rd_lat_leg_a: assert property (@(posedge link_clk) disable iff (srst)
        tk && legacy_mode |-> ##2 vpair_s) else $error("legacy read valid misplaced");
    // valid only for a taken read
    valid_cause_a: assert property (@(posedge link_clk) disable iff (srst) read_output_valid |->
        (legacy_mode ? ($past(tk, 2) || $past(tk, 3)) : ($past(tk, 3) || $past(tk, 4))))
        else $error("valid without read");
    oe_cover_a: assert property (@(posedge link_clk) disable iff (srst)
        read_output_valid |-> read_data_oe) else $error("valid data not driven");
    oe_tail_a: assert property (@(negedge link_clk) disable iff (srst)
        !read_output_valid && $past(read_output_valid) |-> read_data_oe) else $error("float too early");
    oe_off_a: assert property (@(posedge link_clk) disable iff (srst)
        $fell(read_output_valid) |-> !read_data_oe) else $error("float too late");
    echo_follow_a: assert property (@(posedge clk) disable iff (srst)
        echo_clock == link_clk) else $error("echo clock off");
    echo_inv_a: assert property (@(posedge clk) disable iff (srst)
        echo_clock_n != echo_clock) else $error("echo pair not complementary");
    legacy_hold_a: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> $stable(legacy_mode)) else $error("legacy mode moved");
endmodule : qbs_chk

// *** sim/qbs_ctrl_model.sv ***
// Memory controller model driving the burst SRAM pins
`timescale 1ns/100ps
module qbs_ctrl_model (
    input  wire logic                       link_clk,
    output logic                            write_port_select_n,
    output logic                            read_port_select_n,
    output logic      [qbs_pkg::ADDR_W-1:0] address,
    output logic      [qbs_pkg::DATA_W-1:0] write_data,
    output logic      [qbs_pkg::LANES-1:0]  byte_lane_write_select_n,
    input  wire logic [qbs_pkg::DATA_W-1:0] read_data,
    input  wire logic                       read_output_valid
);
    initial begin
        write_port_select_n = 1'b1;
        read_port_select_n = 1'b1;
        address = '0;
        write_data = '0;
        byte_lane_write_select_n = '1;
    end
    // four beats, lines inverted once released
    task automatic wr(input logic [17:0] a, input logic [143:0] d, input logic [15:0] b);
        for (int i = 0; i < 4; i++) begin
            if (i % 2) @(posedge link_clk);
            else @(negedge link_clk);
            #40;
            write_port_select_n = (i != 0);
            address = (i == 0) ? a : ~a;
            write_data = d[36*i +: 36];
            byte_lane_write_select_n = b[4*i +: 4];
        end
        @(negedge link_clk);
        #40;
        write_data = ~write_data;
        byte_lane_write_select_n = ~byte_lane_write_select_n;
    endtask : wr
    task automatic rd(input logic [17:0] a, input int lat, output logic [143:0] q, output logic [3:0] v);
        @(negedge link_clk);
        #40;
        read_port_select_n = 1'b0;
        address = a;
        @(posedge link_clk);
        #40;
        read_port_select_n = 1'b1;
        address = ~a;
        for (int i = 0; i < 4; i++) begin
            if (i == 0) repeat (lat) @(posedge link_clk);
            else if (i % 2) @(negedge link_clk);
            else @(posedge link_clk);
            #40;
            q[36*i +: 36] = read_data;
            v[i] = read_output_valid;
        end
    endtask : rd
endmodule : qbs_ctrl_model

// *** sim/tb_top.sv ***
// Self-checking bench for the burst SRAM port logic
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
    logic                       clk = 1'b0;
    logic                       link_clk = 1'b0;
    logic                       srst = 1'b1;
    logic                       pll_disable_n = 1'b1;
    logic                       legacy_mode, read_data_oe, read_output_valid, echo_clock, echo_clock_n;
    logic                       write_port_select_n, read_port_select_n;
    logic [qbs_pkg::ADDR_W-1:0] address;
    logic [qbs_pkg::DATA_W-1:0] write_data, read_data;
    logic [qbs_pkg::LANES-1:0]  byte_lane_write_select_n;
    logic [143:0]               q, p1;
    logic [3:0]                 v;
    int                         bad_count = 0;
    int                         n_tests = 0;
    always #25 clk = ~clk;
    // Odd offset keeps link edges off the system clock edges
    initial #3 forever #80 link_clk = ~link_clk;
    qbs_top qbs_top_inst (.clk, .srst, .pll_disable_n, .legacy_mode, .link_clk, .write_port_select_n,
        .read_port_select_n, .address, .write_data, .byte_lane_write_select_n, .read_data, .read_data_oe,
        .read_output_valid, .echo_clock, .echo_clock_n);
    qbs_ctrl_model qbs_ctrl_model_inst (.link_clk, .write_port_select_n, .read_port_select_n, .address,
        .write_data, .byte_lane_write_select_n, .read_data, .read_output_valid);
    function automatic logic [143:0] mrg(input logic [143:0] o, input logic [143:0] n, input logic [15:0] b);
        for (int j = 0; j < 16; j++) begin
            if (!b[j]) o[9*j +: 9] = n[9*j +: 9];
        end
        return o;
    endfunction : mrg
    task automatic end_sim;
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic do_rst(input logic pll);
        @(negedge clk);
        srst = 1'b1;
        pll_disable_n = pll;
        repeat (12) @(negedge clk);
        `CHK("rst_outputs", 2'b00, {read_data_oe, read_output_valid});
        srst = 1'b0;
        repeat (5) @(posedge link_clk);
        `CHK("legacy_mode", ~pll, legacy_mode);
    endtask : do_rst
    task automatic t_wr_rd;
        qbs_ctrl_model_inst.wr(18'h2a5c3, p1, 16'h0000);
        qbs_ctrl_model_inst.rd(18'h2a5c3, 2, q, v);
        `CHK("burst", p1, q);
        `CHK("valid", 4'hf, v);
        @(posedge link_clk);
        #40;
        `CHK("valid_end", 1'b0, read_output_valid);
        `CHK("oe_tail", 1'b1, read_data_oe);
        `CHK("echo_pair", 2'b10, {echo_clock, echo_clock_n});
        @(negedge link_clk);
        #40;
        `CHK("oe_after", 1'b0, read_data_oe);
    endtask : t_wr_rd
    // masked lanes kept, idle bus ignored
    task automatic t_lanes;
        qbs_ctrl_model_inst.wr(18'h2a5c3, ~p1, 16'h5a3c);
        repeat (4) @(posedge link_clk);
        qbs_ctrl_model_inst.rd(18'h2a5c3, 2, q, v);
        `CHK("lanes", mrg(p1, ~p1, 16'h5a3c), q);
    endtask : t_lanes
    task automatic t_legacy;
        do_rst(1'b0);
        qbs_ctrl_model_inst.rd(18'h2a5c3, 1, q, v);
        `CHK("legacy_burst", mrg(p1, ~p1, 16'h5a3c), q);
        `CHK("legacy_valid", 4'hf, v);
    endtask : t_legacy
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        p1 = {36'h3f0f0f0f0, 36'h2c3c3c3c3, 36'h111111111, 36'h0a5a5a5a5};
        do_rst(1'b1);
        t_wr_rd();
        t_lanes();
        t_legacy();
        end_sim();
    end
endmodule : tb_top
bind qbs_top qbs_chk qbs_chk_inst (.clk, .srst, .link_clk, .read_port_select_n, .legacy_mode, .read_data_oe,
    .read_output_valid, .echo_clock, .echo_clock_n);
